// *** event_sources.sv ***
// Model of the peripheral event lines that feed the flag bank.
`timescale 1ns/1ps
`default_nettype none
module event_sources (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [47:0] req,
    output logic      [47:0] ev_q
);
    // Each request leaves one cycle later as a registered copy of req; lines idle low.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ev_q <= 48'h0;
        else
            ev_q <= req;
    end
endmodule : event_sources
`default_nettype wire

// *** irq_flag_bank.sv ***
// Wishbone flag bank holding the second to fourth interrupt flag registers.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_bank (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        timer6_pending,
    input  wire logic        timer7_pending,
    input  wire logic        timer8_pending,
    input  wire logic        timer9_pending,
    input  wire logic        xfer_ch3_done_pending,
    input  wire logic        xfer_ch4_done_pending,
    input  wire logic        xfer_ch5_done_pending,
    input  wire logic        xfer_ch6_done_pending,
    input  wire logic        xfer_ch7_done_pending,
    input  wire logic [3:0]  out_compare_pending,
    input  wire logic [3:0]  in_capture_pending,
    input  wire logic        can_ctrl1_event_pending,
    input  wire logic        can_ctrl1_rx_ready_pending,
    input  wire logic        can_ctrl1_tx_request_pending,
    input  wire logic        can_ctrl2_event_pending,
    input  wire logic        can_ctrl2_rx_ready_pending,
    input  wire logic        can_ctrl2_tx_request_pending,
    input  wire logic        serial_port2_event_pending,
    input  wire logic        serial_port2_error_pending,
    input  wire logic        twowire2_master_pending,
    input  wire logic        twowire2_slave_pending,
    input  wire logic        ext_irq3_pending,
    input  wire logic        ext_irq4_pending,
    input  wire logic        async1_error_pending,
    input  wire logic        async2_error_pending,
    output logic      [15:0] irq_flags_group2,
    output logic      [15:0] irq_flags_group3,
    output logic      [15:0] irq_flags_group4
);
    logic [15:0] ev2;
    logic [15:0] ev3;
    logic [15:0] ev4;
    logic        req;
    logic        hit2;
    logic        hit3;
    logic        hit4;
    logic        hit;
    logic        wr_ok;
    logic [15:0] rd_mux;

    always_comb
    begin
        ev2 = 16'h0000;
        ev2[irq_flag_bank_pkg::B2_TIMER6]     = timer6_pending;
        ev2[irq_flag_bank_pkg::B2_XFER_CH4]   = xfer_ch4_done_pending;
        ev2[irq_flag_bank_pkg::B2_OCMP8:irq_flag_bank_pkg::B2_OCMP5]
            = out_compare_pending;
        ev2[irq_flag_bank_pkg::B2_ICAP6:irq_flag_bank_pkg::B2_ICAP3]
            = in_capture_pending;
        ev2[irq_flag_bank_pkg::B2_XFER_CH3]   = xfer_ch3_done_pending;
        ev2[irq_flag_bank_pkg::B2_CAN1_EVENT] = can_ctrl1_event_pending;
        ev2[irq_flag_bank_pkg::B2_CAN1_RX]    = can_ctrl1_rx_ready_pending;
        ev2[irq_flag_bank_pkg::B2_SER2_EVENT] = serial_port2_event_pending;
        ev2[irq_flag_bank_pkg::B2_SER2_ERROR] = serial_port2_error_pending;
        ev3 = 16'h0000;
        ev3[irq_flag_bank_pkg::B3_XFER_CH5]   = xfer_ch5_done_pending;
        ev3[irq_flag_bank_pkg::B3_CAN2_EVENT] = can_ctrl2_event_pending;
        ev3[irq_flag_bank_pkg::B3_CAN2_RX]    = can_ctrl2_rx_ready_pending;
        ev3[irq_flag_bank_pkg::B3_EXT4]       = ext_irq4_pending;
        ev3[irq_flag_bank_pkg::B3_EXT3]       = ext_irq3_pending;
        ev3[irq_flag_bank_pkg::B3_TIMER9]     = timer9_pending;
        ev3[irq_flag_bank_pkg::B3_TIMER8]     = timer8_pending;
        ev3[irq_flag_bank_pkg::B3_TW2_MASTER] = twowire2_master_pending;
        ev3[irq_flag_bank_pkg::B3_TW2_SLAVE]  = twowire2_slave_pending;
        ev3[irq_flag_bank_pkg::B3_TIMER7]     = timer7_pending;
        ev4 = 16'h0000;
        ev4[irq_flag_bank_pkg::B4_CAN2_TX]    = can_ctrl2_tx_request_pending;
        ev4[irq_flag_bank_pkg::B4_CAN1_TX]    = can_ctrl1_tx_request_pending;
        ev4[irq_flag_bank_pkg::B4_XFER_CH7]   = xfer_ch7_done_pending;
        ev4[irq_flag_bank_pkg::B4_XFER_CH6]   = xfer_ch6_done_pending;
        ev4[irq_flag_bank_pkg::B4_ASYNC2_ERR] = async2_error_pending;
        ev4[irq_flag_bank_pkg::B4_ASYNC1_ERR] = async1_error_pending;
    end

    // A request is taken once; ack drops in the following cycle.
    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit2  = wb_adr_i == irq_flag_bank_pkg::OFS_GROUP2;
    assign hit3  = wb_adr_i == irq_flag_bank_pkg::OFS_GROUP3;
    assign hit4  = wb_adr_i == irq_flag_bank_pkg::OFS_GROUP4;
    assign hit   = hit2 || hit3 || hit4;
    assign wr_ok = req && wb_we_i && hit;

    irq_flag_reg #(
        .IMPL_MASK (irq_flag_bank_pkg::MASK_GROUP2)
    ) u_group2 (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_lo   (wr_ok && hit2 && wb_sel_i[0]),
        .wr_hi   (wr_ok && hit2 && wb_sel_i[1]),
        .wr_data (wb_dat_i[15:0]),
        .events  (ev2),
        .flags_q (irq_flags_group2)
    );

    irq_flag_reg #(
        .IMPL_MASK (irq_flag_bank_pkg::MASK_GROUP3)
    ) u_group3 (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_lo   (wr_ok && hit3 && wb_sel_i[0]),
        .wr_hi   (wr_ok && hit3 && wb_sel_i[1]),
        .wr_data (wb_dat_i[15:0]),
        .events  (ev3),
        .flags_q (irq_flags_group3)
    );

    irq_flag_reg #(
        .IMPL_MASK (irq_flag_bank_pkg::MASK_GROUP4)
    ) u_group4 (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_lo   (wr_ok && hit4 && wb_sel_i[0]),
        .wr_hi   (wr_ok && hit4 && wb_sel_i[1]),
        .wr_data (wb_dat_i[15:0]),
        .events  (ev4),
        .flags_q (irq_flags_group4)
    );

    always_comb
    begin
        rd_mux = 16'h0000;
        if (hit2)
            rd_mux = irq_flags_group2;
        else if (hit3)
            rd_mux = irq_flags_group3;
        else if (hit4)
            rd_mux = irq_flags_group4;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_we_i && hit)
            wb_dat_o <= {16'h0000, rd_mux};
    end

    ack_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle.");

    ack_timing_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req && hit |=> wb_ack_o)
        else $error("Mapped access not acknowledged next cycle.");

    timer6_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        timer6_pending |=> irq_flags_group2[15])
        else $error("Timer six flag not set.");

    timer7_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        timer7_pending |=> irq_flags_group3[0])
        else $error("Timer seven flag not set.");

    timer8_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        timer8_pending |=> irq_flags_group3[3])
        else $error("Timer eight flag not set.");

    timer9_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        timer9_pending |=> irq_flags_group3[4])
        else $error("Timer nine flag not set.");

    can2_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        can_ctrl2_tx_request_pending |=> irq_flags_group4[7])
        else $error("Bus controller two transmit flag not set.");

    can2_ev_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        can_ctrl2_event_pending |=> irq_flags_group3[8])
        else $error("Bus controller two event flag not set.");

    can2_rx_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        can_ctrl2_rx_ready_pending |=> irq_flags_group3[7])
        else $error("Bus controller two receive flag not set.");

    ser_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        serial_port2_error_pending |=> irq_flags_group2[0])
        else $error("Serial port error flag not set.");

    ser_ev_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        serial_port2_event_pending |=> irq_flags_group2[1])
        else $error("Serial port event flag not set.");

    tw_master_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        twowire2_master_pending |=> irq_flags_group3[2])
        else $error("Two-wire master flag not set.");

    tw_slave_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        twowire2_slave_pending |=> irq_flags_group3[1])
        else $error("Two-wire slave flag not set.");

    ext_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ext_irq4_pending |=> irq_flags_group3[6])
        else $error("External four flag not set.");

    ext3_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ext_irq3_pending |=> irq_flags_group3[5])
        else $error("External three flag not set.");

    async1_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        async1_error_pending |=> irq_flags_group4[1])
        else $error("Async one error flag not set.");

    async2_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        async2_error_pending |=> irq_flags_group4[2])
        else $error("Async two error flag not set.");

    xfer_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        xfer_ch5_done_pending |=> irq_flags_group3[13])
        else $error("Transfer five flag not set.");

    xfer3_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        xfer_ch3_done_pending |=> irq_flags_group2[4])
        else $error("Transfer three flag not set.");

    xfer4_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        xfer_ch4_done_pending |=> irq_flags_group2[14])
        else $error("Transfer four flag not set.");

    xfer6_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        xfer_ch6_done_pending |=> irq_flags_group4[4])
        else $error("Transfer six flag not set.");

    xfer7_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        xfer_ch7_done_pending |=> irq_flags_group4[5])
        else $error("Transfer seven flag not set.");

    can1_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        can_ctrl1_event_pending |=> irq_flags_group2[3])
        else $error("Bus controller one event flag not set.");

    can1_rx_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        can_ctrl1_rx_ready_pending |=> irq_flags_group2[2])
        else $error("Bus controller one receive flag not set.");

    can1_tx_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        can_ctrl1_tx_request_pending |=> irq_flags_group4[6])
        else $error("Bus controller one transmit flag not set.");

    ocmp_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        out_compare_pending[3] |=> irq_flags_group2[12])
        else $error("Compare eight flag not set.");

    ocmp5_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        out_compare_pending[0] |=> irq_flags_group2[9])
        else $error("Compare five flag not set.");

    icap3_pos_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        in_capture_pending[0] |=> irq_flags_group2[5])
        else $error("Capture three flag not set.");

    reset_clear_a: assert property (
        @(posedge clk_sys)
        !rst_n |=> irq_flags_group2 == 16'h0000
            && irq_flags_group3 == 16'h0000
            && irq_flags_group4 == 16'h0000)
        else $error("Flags not cleared by reset.");

    read_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("Upper read data not zero.");

endmodule : irq_flag_bank
`default_nettype wire

// *** irq_flag_bank_pkg.sv ***
// Package with register map, field positions and masks of the flag bank.
package irq_flag_bank_pkg;

    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned FLAG_W     = 16;
    localparam int unsigned GROUP_CNT  = 3;

    // Byte offsets of the three flag registers on the bus.
    localparam logic [3:0] OFS_GROUP2 = 4'h0;
    localparam logic [3:0] OFS_GROUP3 = 4'h4;
    localparam logic [3:0] OFS_GROUP4 = 4'h8;

    localparam logic [15:0] RESET_VALUE = 16'h0000;

    // Implemented bit masks of each register.
    localparam logic [15:0] MASK_GROUP2 = 16'hDFFF;
    localparam logic [15:0] MASK_GROUP3 = 16'h21FF;
    localparam logic [15:0] MASK_GROUP4 = 16'h00F6;

    // Second register field positions.
    localparam int unsigned B2_TIMER6     = 15;
    localparam int unsigned B2_XFER_CH4   = 14;
    localparam int unsigned B2_OCMP8      = 12;
    localparam int unsigned B2_OCMP5      = 9;
    localparam int unsigned B2_ICAP6      = 8;
    localparam int unsigned B2_ICAP3      = 5;
    localparam int unsigned B2_XFER_CH3   = 4;
    localparam int unsigned B2_CAN1_EVENT = 3;
    localparam int unsigned B2_CAN1_RX    = 2;
    localparam int unsigned B2_SER2_EVENT = 1;
    localparam int unsigned B2_SER2_ERROR = 0;

    // Third register field positions.
    localparam int unsigned B3_XFER_CH5   = 13;
    localparam int unsigned B3_CAN2_EVENT = 8;
    localparam int unsigned B3_CAN2_RX    = 7;
    localparam int unsigned B3_EXT4       = 6;
    localparam int unsigned B3_EXT3       = 5;
    localparam int unsigned B3_TIMER9     = 4;
    localparam int unsigned B3_TIMER8     = 3;
    localparam int unsigned B3_TW2_MASTER = 2;
    localparam int unsigned B3_TW2_SLAVE  = 1;
    localparam int unsigned B3_TIMER7     = 0;

    // Fourth register field positions.
    localparam int unsigned B4_CAN2_TX    = 7;
    localparam int unsigned B4_CAN1_TX    = 6;
    localparam int unsigned B4_XFER_CH7   = 5;
    localparam int unsigned B4_XFER_CH6   = 4;
    localparam int unsigned B4_ASYNC2_ERR = 2;
    localparam int unsigned B4_ASYNC1_ERR = 1;

endpackage : irq_flag_bank_pkg

// *** irq_flag_reg.sv ***
// One sticky flag register with software write and event set.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_reg #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        wr_lo,
    input  wire logic        wr_hi,
    input  wire logic [15:0] wr_data,
    input  wire logic [15:0] events,
    output logic      [15:0] flags_q
);
    logic [15:0] flags_d;
    logic [15:0] lane_mask;

    always_comb
    begin
        lane_mask = {{8{wr_hi}}, {8{wr_lo}}};
        flags_d   = (flags_q & ~lane_mask) | (wr_data & lane_mask);
        flags_d   = (flags_d | events) & IMPL_MASK;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            flags_q <= irq_flag_bank_pkg::RESET_VALUE;
        else
            flags_q <= flags_d;
    end

    unimpl_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 (flags_q & ~IMPL_MASK) == 16'h0000)
        else $error("Unimplemented flag bit reads one.");

    event_wins_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (events & IMPL_MASK) != 16'h0000
        |=> (flags_q & $past(events) & IMPL_MASK)
            == ($past(events) & IMPL_MASK))
        else $error("Event lost against software write.");

    hold_set_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !wr_lo && !wr_hi |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("Pending flag dropped without a write.");

endmodule : irq_flag_reg
`default_nettype wire

// *** test_interrupt_flag_status_bank_two_to_four.sv ***
// Self-checking testbench for the interrupt flag bank.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_flag_status_bank_two_to_four;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        wb_err_o;
    logic [47:0] req = 48'h0;
    wire  [47:0] ev;
    wire  [47:0] flg;
    logic [15:0] exp_q [3];
    int          seed = 90;
    int          num_errors = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #25 clk_sys = ~clk_sys;

    event_sources src (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
        .ev_q(ev));
    irq_flag_bank uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .timer6_pending(ev[15]), .xfer_ch4_done_pending(ev[14]),
        .out_compare_pending(ev[12:9]), .in_capture_pending(ev[8:5]),
        .xfer_ch3_done_pending(ev[4]), .can_ctrl1_event_pending(ev[3]),
        .can_ctrl1_rx_ready_pending(ev[2]),
        .serial_port2_event_pending(ev[1]),
        .serial_port2_error_pending(ev[0]),
        .xfer_ch5_done_pending(ev[29]), .can_ctrl2_event_pending(ev[24]),
        .can_ctrl2_rx_ready_pending(ev[23]), .ext_irq4_pending(ev[22]),
        .ext_irq3_pending(ev[21]), .timer9_pending(ev[20]),
        .timer8_pending(ev[19]), .twowire2_master_pending(ev[18]),
        .twowire2_slave_pending(ev[17]), .timer7_pending(ev[16]),
        .can_ctrl2_tx_request_pending(ev[39]),
        .can_ctrl1_tx_request_pending(ev[38]),
        .xfer_ch7_done_pending(ev[37]), .xfer_ch6_done_pending(ev[36]),
        .async2_error_pending(ev[34]), .async1_error_pending(ev[33]),
        .irq_flags_group2(flg[15:0]), .irq_flags_group3(flg[31:16]),
        .irq_flags_group4(flg[47:32]));

    function automatic logic [15:0] mask_of(input int g);
        return g == 0 ? irq_flag_bank_pkg::MASK_GROUP2 : g == 1 ?
            irq_flag_bank_pkg::MASK_GROUP3 : irq_flag_bank_pkg::MASK_GROUP4;
    endfunction : mask_of

    function automatic logic [3:0] adr_of(input int g);
        return g == 0 ? irq_flag_bank_pkg::OFS_GROUP2 : g == 1 ?
            irq_flag_bank_pkg::OFS_GROUP3 : irq_flag_bank_pkg::OFS_GROUP4;
    endfunction : adr_of

    function automatic logic [15:0] merged(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] n;
        n = old;
        if (sel[0]) n[7:0] = d[7:0];
        if (sel[1]) n[15:8] = d[15:8];
        return n;
    endfunction : merged

    task automatic chk(input logic [47:0] got, input logic [47:0] want,
        input string what);
        check_count++;
        if (got !== want)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
        end
    endtask : chk

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic wb(input logic we, input logic [3:0] adr,
        input logic [3:0] sel, input logic [31:0] d, input logic [47:0] evv,
        output logic [31:0] rd, output logic er);
        @(posedge clk_sys);
        req <= evv;
        @(posedge clk_sys);
        req <= 48'h0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_sys);
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic wr(input int g, input logic [31:0] d,
        input logic [3:0] sel, input logic [47:0] evv);
        logic [31:0] rd;
        logic        er;
        wb(1'b1, adr_of(g), sel, d, evv, rd, er);
        for (int h = 0; h < 3; h++)
            exp_q[h] = ((h == g ? merged(exp_q[h], d, sel) : exp_q[h])
                | evv[16*h +: 16]) & mask_of(h);
        chk(48'(er), 48'h0, "write err");
    endtask : wr

    task automatic rd_chk(input int g);
        logic [31:0] rd;
        logic        er;
        wb(1'b0, adr_of(g), 4'hF, 32'h0, 48'h0, rd, er);
        chk(48'(rd), 48'(exp_q[g]), "read");
        chk(flg, {exp_q[2], exp_q[1], exp_q[0]}, "flags");
    endtask : rd_chk

    task automatic pulse(input logic [47:0] v);
        @(posedge clk_sys);
        req <= v;
        @(posedge clk_sys);
        req <= 48'h0;
        repeat (2) @(posedge clk_sys);
        for (int h = 0; h < 3; h++)
            exp_q[h] |= v[16*h +: 16] & mask_of(h);
        chk(flg, {exp_q[2], exp_q[1], exp_q[0]}, "event");
    endtask : pulse

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    initial
    begin
        int          g;
        logic [47:0] v;
        logic [31:0] rd;
        logic        er;
        foreach (exp_q[i]) exp_q[i] = 16'h0;
        repeat (20) @(posedge clk_sys);
        chk(flg, 48'h0, "reset flags");
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(i);
        $display("reset test done");
        for (int i = 0; i < 3; i++)
        begin
            wr(i, 32'h0000FFFF, 4'h3, 48'h0);
            rd_chk(i);
            wr(i, 32'h0, 4'h3, 48'h0);
            rd_chk(i);
        end
        wr(0, 32'h0000FFFF, 4'h1, 48'h0);
        rd_chk(0);
        $display("access test done");
        for (int b = 0; b < 48; b++)
        begin
            pulse(48'h1 << b);
            rd_chk(b / 16);
            wr(b / 16, 32'h0, 4'h3, 48'h0);
        end
        $display("position test done");
        wr(1, 32'h0000FFFF, 4'h3, 48'h0);
        wr(1, 32'h0, 4'h3, 48'h1 << 16);
        rd_chk(1);
        repeat (200)
        begin
            g = $unsigned($random(seed)) % 3;
            v = 48'({$random(seed), $random(seed)})
                & 48'({$random(seed), $random(seed)});
            if ($random(seed) & 1)
                wr(g, $random(seed), 4'($random(seed)), v);
            else
                pulse(v);
            rd_chk(g);
        end
        $display("random test done");
        pulse({48{1'b1}});
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(flg, 48'h0, "mid reset flags");
        rst_n <= 1'b1;
        foreach (exp_q[i]) exp_q[i] = 16'h0;
        for (int i = 0; i < 3; i++) rd_chk(i);
        $display("mid reset test done");
        wb(1'b1, 4'hC, 4'h3, 32'h0000FFFF, 48'h0, rd, er);
        chk(48'(er), 48'h1, "unmapped err");
        for (int i = 0; i < 3; i++) rd_chk(i);
        $display("unmapped test done");
        summarize();
    end
endmodule : test_interrupt_flag_status_bank_two_to_four
`default_nettype wire
